// >>> design/phad_top.sv
// port h open-drain and serial routing, analog port general purpose i/o, apb slave
//
// Overview of operation
// - port h open-drain bit set: pin only pulled low; clear: push-pull.
// - open-drain bits do nothing on pins used as inputs.
// - route bit 0 puts serial port one on port h 1:0 or port m 1:0.
// - analog port outputs drive data bits; low half bits 3:0, high 7:0.
// - data read returns register bit when output, synced pin when input.
// - direction bit 1 makes pin output, 0 input; low 3:0, high 7:0.
// - digital input path usable only with converter digital enable set.
// - data readback may lag a direction change by up to two cycles; here up to five edges.
// - low-half pull enable turns pull device on; ignored on outputs.
// - pull direction follows the polarity select bit.
// - reserved locations read zero and ignore writes.
// - these registers read and write at any time.
// - analog input function overrides general purpose i/o.
// - routed and enabled serial port sets port h 1:0 direction.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module phad_top (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port h controls from the neighbouring port h registers
  input wire logic [phad_pkg::PHAD_PH_W-1:0] port_h_direction,
  input wire logic [phad_pkg::PHAD_PH_W-1:0] port_h_data,
  // port h pads
  input wire logic [phad_pkg::PHAD_PH_W-1:0] port_h_pins_in,
  output phad_pkg::phad_ph_drive_t port_h_pins_drv,
  // port m pads used by serial port one
  input wire logic port_m_rx_in,
  output logic port_m_tx_out,
  output logic port_m_tx_oe_n,
  // serial port one
  input wire logic serial_port_one_en,
  input wire logic serial_port_one_txd,
  output logic serial_port_one_rxd,
  // analog converter side
  input wire logic [phad_pkg::PHAD_AD_W-1:0] converter_digital_input_enable,
  input wire logic [phad_pkg::PHAD_AD_W-1:0] analog_converter_active,
  // analog port pads
  input wire logic [phad_pkg::PHAD_AD_W-1:0] analog_pins_in,
  output phad_pkg::phad_ad_drive_t analog_pins_drv,
  output phad_pkg::phad_pull_t analog_pins_pull
);

  import phad_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] od_sel_reg;
  logic [7:0] route_reg;
  logic [PHAD_LO_W-1:0] lo_data_reg;
  logic [PHAD_HI_W-1:0] hi_data_reg;
  logic [PHAD_LO_W-1:0] lo_dir_reg;
  logic [PHAD_HI_W-1:0] hi_dir_reg;
  logic [PHAD_LO_W-1:0] lo_pull_reg;
  logic [PHAD_LO_W-1:0] lo_pol_reg;

  logic setup;
  logic wr_access;
  logic [PHAD_AD_W-1:0] ad_sync;
  logic [PHAD_PH_W-1:0] ph_sync_n;
  logic pm_rx_sync_n;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= PHAD_OFF_RSV_LAST);
  endfunction

  // register writes take effect at the access edge, any time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      od_sel_reg <= PHAD_RST_OD_SEL;
      route_reg <= PHAD_RST_ROUTE;
      lo_data_reg <= PHAD_RST_DATA[PHAD_LO_W-1:0];
      hi_data_reg <= PHAD_RST_DATA[PHAD_HI_W-1:0];
      lo_dir_reg <= PHAD_RST_DIR[PHAD_LO_W-1:0];
      hi_dir_reg <= PHAD_RST_DIR[PHAD_HI_W-1:0];
      lo_pull_reg <= PHAD_RST_PULL[PHAD_LO_W-1:0];
      lo_pol_reg <= PHAD_RST_POL[PHAD_LO_W-1:0];
    end else if (wr_access) begin
      case (paddr)
        PHAD_OFF_OD_SEL: od_sel_reg <= pwdata[7:0];
        PHAD_OFF_ROUTE: route_reg <= {7'h00, pwdata[PHAD_ROUTE_BIT]};
        PHAD_OFF_LO_DATA: lo_data_reg <= pwdata[PHAD_LO_W-1:0];
        PHAD_OFF_HI_DATA: hi_data_reg <= pwdata[PHAD_HI_W-1:0];
        PHAD_OFF_LO_DIR: lo_dir_reg <= pwdata[PHAD_LO_W-1:0];
        PHAD_OFF_HI_DIR: hi_dir_reg <= pwdata[PHAD_HI_W-1:0];
        PHAD_OFF_LO_PULL: lo_pull_reg <= pwdata[PHAD_LO_W-1:0];
        PHAD_OFF_LO_POL: lo_pol_reg <= pwdata[PHAD_LO_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // one shared instance keeps all pad inputs on the same latency
  // serial-capable pads are held inverted: the cleared synchroniser then
  // matches an idle-high line, so no false start bit follows reset
  phad_sync #(
    .WIDTH(PHAD_AD_W + PHAD_PH_W + 1)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({~port_m_rx_in, ~port_h_pins_in, analog_pins_in}),
    .q({pm_rx_sync_n, ph_sync_n, ad_sync})
  );

  //////////////////////////////////////////////////////////////////////////////
  // analog port read path

  logic [PHAD_AD_W-1:0] ad_dir;
  logic [PHAD_AD_W-1:0] ad_data;
  logic [PHAD_AD_W-1:0] ad_in_gated;
  logic [PHAD_AD_W-1:0] ad_read;

  assign ad_dir = {hi_dir_reg, lo_dir_reg};
  assign ad_data = {hi_data_reg, lo_data_reg};
  // digital input only when the converter lets it through
  assign ad_in_gated = ad_sync & converter_digital_input_enable;
  // input pins show the synced pad, hence the lag after a direction write
  assign ad_read = (ad_dir & ad_data) | (~ad_dir & ad_in_gated);

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, data latched in the setup cycle

  logic [31:0] rd_next;

  always_comb begin
    rd_next = PHAD_RD_ZERO;
    case (paddr)
      PHAD_OFF_OD_SEL: rd_next[7:0] = od_sel_reg;
      PHAD_OFF_ROUTE: rd_next[7:0] = route_reg;
      PHAD_OFF_LO_DATA: rd_next[PHAD_LO_W-1:0] = ad_read[PHAD_LO_W-1:0];
      PHAD_OFF_HI_DATA: rd_next[PHAD_HI_W-1:0] = ad_read[PHAD_AD_W-1:PHAD_LO_W];
      PHAD_OFF_LO_DIR: rd_next[PHAD_LO_W-1:0] = lo_dir_reg;
      PHAD_OFF_HI_DIR: rd_next[PHAD_HI_W-1:0] = hi_dir_reg;
      PHAD_OFF_LO_PULL: rd_next[PHAD_LO_W-1:0] = lo_pull_reg;
      PHAD_OFF_LO_POL: rd_next[PHAD_LO_W-1:0] = lo_pol_reg;
      default: rd_next = PHAD_RD_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= PHAD_RD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? PHAD_RD_ZERO : rd_next;
      pready <= 1'b1;
      pslverr <= !is_mapped(paddr);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog port pad drive and pulls

  logic [PHAD_AD_W-1:0] ad_gpio_out;
  logic [PHAD_LO_W-1:0] lo_is_input;

  // converter use of the pin outranks general purpose output
  assign ad_gpio_out = ad_dir & ~analog_converter_active;
  assign lo_is_input = ~lo_dir_reg & ~analog_converter_active[PHAD_LO_W-1:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      analog_pins_drv.out <= '0;
      analog_pins_drv.oe_n <= '1;
      analog_pins_pull.en <= '0;
      analog_pins_pull.down <= '0;
    end else begin
      analog_pins_drv.out <= ad_data;
      analog_pins_drv.oe_n <= ~ad_gpio_out;
      analog_pins_pull.en <= lo_pull_reg & lo_is_input;
      analog_pins_pull.down <= lo_pol_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port h pad drive and serial port one routing

  logic route_pm;
  logic sci_on_ph;
  logic sci_on_pm;
  logic [PHAD_PH_W-1:0] ph_dir;
  logic [PHAD_PH_W-1:0] ph_val;

  assign route_pm = route_reg[PHAD_ROUTE_BIT];
  assign sci_on_ph = serial_port_one_en && !route_pm;
  assign sci_on_pm = serial_port_one_en && route_pm;

  // serial port owns pins 1:0 direction while routed here and enabled
  always_comb begin
    ph_dir = port_h_direction;
    ph_val = port_h_data;
    if (sci_on_ph) begin
      ph_dir[PHAD_TX_PIN] = 1'b1;
      ph_dir[PHAD_RX_PIN] = 1'b0;
      ph_val[PHAD_TX_PIN] = serial_port_one_txd;
    end
  end

  // open-drain only masks driving a one; inputs stay undriven either way
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_h_pins_drv.out <= '0;
      port_h_pins_drv.oe_n <= '1;
    end else begin
      port_h_pins_drv.out <= ph_val;
      port_h_pins_drv.oe_n <= ~ph_dir | (od_sel_reg & ph_val);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_m_tx_out <= 1'b1;
      port_m_tx_oe_n <= 1'b1;
      serial_port_one_rxd <= 1'b1;
    end else begin
      port_m_tx_out <= serial_port_one_txd;
      port_m_tx_oe_n <= !sci_on_pm;
      serial_port_one_rxd <= route_pm ? !pm_rx_sync_n : !ph_sync_n[PHAD_RX_PIN];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_od_no_high;
    od_sel_reg[0] && port_h_direction[0] && port_h_data[0] && !sci_on_ph
      |=> port_h_pins_drv.oe_n[0];
  endproperty
  a_od_no_high: assert property (p_od_no_high) else $error("open-drain pin drove high");

  property p_pp_high;
    !od_sel_reg[2] && port_h_direction[2] && port_h_data[2]
      |=> !port_h_pins_drv.oe_n[2] && port_h_pins_drv.out[2];
  endproperty
  a_pp_high: assert property (p_pp_high) else $error("push-pull pin not driving");

  property p_od_input;
    !port_h_direction[3] |=> port_h_pins_drv.oe_n[3];
  endproperty
  a_od_input: assert property (p_od_input) else $error("input pin was driven");

  property p_route_pm;
    sci_on_pm |=> !port_m_tx_oe_n && port_m_tx_out == $past(serial_port_one_txd);
  endproperty
  a_route_pm: assert property (p_route_pm) else $error("port m tx not driven");

  property p_route_ph;
    sci_on_ph |=> port_h_pins_drv.oe_n[PHAD_RX_PIN]
      && port_h_pins_drv.out[PHAD_TX_PIN] == $past(serial_port_one_txd);
  endproperty
  a_route_ph: assert property (p_route_ph) else $error("port h serial pins wrong");

  property p_ad_drive;
    ad_dir[5] && !analog_converter_active[5]
      |=> !analog_pins_drv.oe_n[5] && analog_pins_drv.out[5] == $past(ad_data[5]);
  endproperty
  a_ad_drive: assert property (p_ad_drive) else $error("analog pin not driving data");

  property p_ad_alt;
    analog_converter_active[1] |=> analog_pins_drv.oe_n[1] && !analog_pins_pull.en[1];
  endproperty
  a_ad_alt: assert property (p_ad_alt) else $error("converter pin still driven");

  property p_read_out;
    setup && !pwrite && paddr == PHAD_OFF_HI_DATA && hi_dir_reg == 8'hFF
      |=> prdata[7:0] == $past(hi_data_reg) && pready;
  endproperty
  a_read_out: assert property (p_read_out) else $error("output readback wrong");

  property p_read_gate;
    setup && !pwrite && paddr == PHAD_OFF_LO_DATA && !lo_dir_reg[0]
      && !converter_digital_input_enable[0] |=> !prdata[0];
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("disabled input read high");

  property p_pull_out;
    lo_dir_reg[2] |=> !analog_pins_pull.en[2];
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull on output pin");

  property p_rsv;
    setup && !pwrite && paddr > PHAD_OFF_LO_POL && paddr <= PHAD_OFF_RSV_LAST
      && paddr[1:0] == 2'b00 |=> prdata == PHAD_RD_ZERO && !pslverr;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved word not zero");

  property p_ready;
    setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer timing wrong");

  property p_pull_pol;
    lo_pull_reg[3] && !lo_dir_reg[3] && !analog_converter_active[3]
      |=> analog_pins_pull.en[3] && analog_pins_pull.down[3] == $past(lo_pol_reg[3]);
  endproperty
  a_pull_pol: assert property (p_pull_pol) else $error("pull polarity not followed");

  property p_dir_in;
    !ad_dir[7] |=> analog_pins_drv.oe_n[7];
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("analog input pin driven");

  property p_read_in;
    setup && !pwrite && paddr == PHAD_OFF_LO_DATA && !lo_dir_reg[1]
      && converter_digital_input_enable[1] |=> prdata[1] == $past(ad_sync[1]);
  endproperty
  a_read_in: assert property (p_read_in) else $error("input readback wrong");

  // a level held for two edges must reach the filtered output three edges later
  property p_sync_lag;
    analog_pins_in[2] ##1 analog_pins_in[2] |=> ##2 ad_sync[2];
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("pad input not synchronised");

  property p_slverr;
    setup && paddr[1:0] != 2'b00 |=> pready && pslverr && prdata == PHAD_RD_ZERO;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unaligned access not refused");

  c_route_pm: cover property (sci_on_pm ##1 !port_m_tx_oe_n);
  c_od_low: cover property (od_sel_reg[1] && port_h_direction[1] ##1 !port_h_pins_drv.oe_n[1]);
  c_in_read: cover property (setup && paddr == PHAD_OFF_LO_DATA ##1 prdata[0]);
  c_pull_dn: cover property (analog_pins_pull.en[0] && analog_pins_pull.down[0]);
  c_slverr: cover property (setup ##1 pslverr);

endmodule

// >>> design/phad_pkg.sv
// package: register map, reset values and pin bundles for the port h / analog port slice
package phad_pkg;

  // apb word offsets (byte addresses)
  localparam logic [7:0] PHAD_OFF_OD_SEL = 8'h00;
  localparam logic [7:0] PHAD_OFF_ROUTE = 8'h04;
  localparam logic [7:0] PHAD_OFF_LO_DATA = 8'h08;
  localparam logic [7:0] PHAD_OFF_HI_DATA = 8'h0C;
  localparam logic [7:0] PHAD_OFF_LO_DIR = 8'h10;
  localparam logic [7:0] PHAD_OFF_HI_DIR = 8'h14;
  localparam logic [7:0] PHAD_OFF_LO_PULL = 8'h18;
  localparam logic [7:0] PHAD_OFF_LO_POL = 8'h1C;
  // reserved words inside the block's window read zero, ignore writes
  localparam logic [7:0] PHAD_OFF_RSV_LAST = 8'h3C;

  // field positions and widths
  localparam int PHAD_ROUTE_BIT = 0;
  localparam int PHAD_LO_W = 4;
  localparam int PHAD_HI_W = 8;
  localparam int PHAD_PH_W = 8;
  localparam int PHAD_AD_W = PHAD_LO_W + PHAD_HI_W;
  localparam int PHAD_TX_PIN = 1;
  localparam int PHAD_RX_PIN = 0;

  // reset values
  localparam logic [7:0] PHAD_RST_OD_SEL = 8'h00;
  localparam logic [7:0] PHAD_RST_ROUTE = 8'h00;
  localparam logic [7:0] PHAD_RST_DATA = 8'h00;
  localparam logic [7:0] PHAD_RST_DIR = 8'h00;
  localparam logic [7:0] PHAD_RST_PULL = 8'h00;
  localparam logic [7:0] PHAD_RST_POL = 8'h00;
  localparam logic [31:0] PHAD_RD_ZERO = 32'h0000_0000;

  // timing: readback lag after a direction change, in bus cycles
  localparam int PHAD_DIR_LAG_CYC = 2;

  // pin drive bundles; oe_n low means the pad drives
  typedef struct packed {
    logic [PHAD_PH_W-1:0] out;
    logic [PHAD_PH_W-1:0] oe_n;
  } phad_ph_drive_t;

  typedef struct packed {
    logic [PHAD_AD_W-1:0] out;
    logic [PHAD_AD_W-1:0] oe_n;
  } phad_ad_drive_t;

  typedef struct packed {
    logic [PHAD_LO_W-1:0] en;
    logic [PHAD_LO_W-1:0] down;
  } phad_pull_t;

endpackage

// >>> design/phad_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module phad_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // asynchronous pins in, filtered level out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // s1 feeds s2 only; nothing else looks at the metastable stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= (s2_reg & s3_reg) | (q & (s2_reg ^ s3_reg)) | (s2_reg & s3_reg);
    end
  end

endmodule

// >>> sim/phad_pins_model.sv
// pad model: resolves port h and analog pad levels from block drives and far-side levels
`timescale 1ns/1ps
module phad_pins_model
  import phad_pkg::*;
(
  // drives from the block
  input wire phad_pkg::phad_ph_drive_t ph_drv,
  input wire phad_pkg::phad_ad_drive_t ad_drv,
  input wire phad_pkg::phad_pull_t ad_pull,
  // far-side levels seen when the block releases a pad
  input wire logic [7:0] ph_ext,
  input wire logic [11:0] ad_ext,
  // resolved pad levels
  output logic [7:0] ph_pin,
  output logic [11:0] ad_pin
);
  ////////////////////////////////////////
  // only the low half has pull devices; an enabled pull wins over the far side
  logic [11:0] rel;
  assign rel = {ad_ext[11:4], (ad_pull.en & ~ad_pull.down) | (~ad_pull.en & ad_ext[3:0])};
  assign ad_pin = (ad_drv.out & ~ad_drv.oe_n) | (rel & ad_drv.oe_n);
  assign ph_pin = (ph_drv.out & ~ph_drv.oe_n) | (ph_ext & ph_drv.oe_n);
endmodule

// >>> sim/phad_top_bench.sv
// self-checking bench for the port h / analog port slice
`timescale 1ns/1ps
module phad_top_bench;
  import phad_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, ph_dir = 0, ph_data = 0, ph_ext = 0, ph_pin;
  logic [31:0] pwdata = 0, prdata, v, p;
  logic pready, pslverr, m_rx = 1, s_en = 0, s_txd = 0, m_tx, m_oe_n, s_rxd;
  logic [11:0] dien = 0, act = 0, ad_ext = 0, ad_pin;
  phad_ph_drive_t ph_drv;
  phad_ad_drive_t ad_drv;
  phad_pull_t pull;
  logic [31:0] exq[$];
  logic [31:0] erq[$];
  int n_fail = 0, compares = 0;
  ////////////////////////////////////////
  always #50 clk = ~clk;
  phad_top i_phad_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_h_direction(ph_dir), .port_h_data(ph_data),
    .port_h_pins_in(ph_pin), .port_h_pins_drv(ph_drv), .port_m_rx_in(m_rx),
    .port_m_tx_out(m_tx), .port_m_tx_oe_n(m_oe_n), .serial_port_one_en(s_en),
    .serial_port_one_txd(s_txd), .serial_port_one_rxd(s_rxd),
    .converter_digital_input_enable(dien), .analog_converter_active(act),
    .analog_pins_in(ad_pin), .analog_pins_drv(ad_drv), .analog_pins_pull(pull));
  phad_pins_model i_phad_pins_model (.ph_drv(ph_drv), .ad_drv(ad_drv), .ad_pull(pull),
    .ph_ext(ph_ext), .ad_ext(ad_ext), .ph_pin(ph_pin), .ad_pin(ad_pin));
  ////////////////////////////////////////
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; a read notes its expected data for the watcher
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exq.push_back(e);
    erq.push_back({31'h0, (a[1:0] != 2'b00) || (a > PHAD_OFF_RSV_LAST)});
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      n_fail++;
      results();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, e);
  endtask
  // pads pass a multi-flop synchroniser, so allow several edges
  task settle;
    repeat (6) @(posedge clk);
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      chk(pslverr, erq.size() == 0 ? 32'hdead_beef : erq.pop_front());
      if (!pwrite && exq.size() == 0)
        chk(prdata, 32'hdead_beef);
      else if (!pwrite)
        chk(prdata, exq.pop_front());
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'he949));
    repeat (4) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 16; i++) rd(8'(i * 4), 32'h0000_0000);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0000_0000);
    rd(8'h41, 32'h0000_0000);
    wr(8'h42, 32'hffff_ffff);
    rd(8'h40, 32'h0000_0000);
    v = $urandom;
    wr(PHAD_OFF_LO_DIR, 32'h0000_000f);
    wr(PHAD_OFF_HI_DIR, 32'h0000_00ff);
    wr(PHAD_OFF_LO_DATA, {28'h0, v[3:0]});
    wr(PHAD_OFF_HI_DATA, {24'h0, v[11:4]});
    rd(PHAD_OFF_LO_DATA, {28'h0, v[3:0]});
    rd(PHAD_OFF_HI_DATA, {24'h0, v[11:4]});
    rd(PHAD_OFF_HI_DIR, 32'h0000_00ff);
    settle();
    chk(ad_drv.out, v[11:0]);
    chk(ad_drv.oe_n, 12'h000);
    p = $urandom;
    act <= p[11:0];
    settle();
    chk(ad_drv.oe_n & p[11:0], p[11:0]);
    act <= 0;
    wr(PHAD_OFF_LO_DIR, 32'h0);
    wr(PHAD_OFF_HI_DIR, 32'h0);
    p = $urandom;
    ad_ext <= p[11:0];
    dien <= p[23:12];
    settle();
    chk(ad_drv.oe_n, 12'hfff);
    rd(PHAD_OFF_LO_DATA, {28'h0, p[3:0] & p[15:12]});
    rd(PHAD_OFF_HI_DATA, {24'h0, p[11:4] & p[23:16]});
    wr(PHAD_OFF_HI_DIR, 32'h0000_00ff);
    rd(PHAD_OFF_HI_DATA, {24'h0, v[11:4]});
    v = $urandom;
    wr(PHAD_OFF_LO_PULL, {28'h0, v[3:0]});
    wr(PHAD_OFF_LO_POL, {28'h0, v[7:4]});
    settle();
    chk(pull.en, v[3:0]);
    chk(pull.down & pull.en, v[7:4] & v[3:0]);
    rd(PHAD_OFF_LO_POL, {28'h0, v[7:4]});
    rd(PHAD_OFF_LO_PULL, {28'h0, v[3:0]});
    rd(PHAD_OFF_LO_DATA, {28'h0, ((v[3:0] & ~v[7:4]) | (~v[3:0] & p[3:0])) & p[15:12]});
    wr(PHAD_OFF_LO_DIR, 32'h0000_000f);
    settle();
    chk(pull.en, 4'h0);
    wr(PHAD_OFF_ROUTE, 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      ph_dir <= v[7:0];
      ph_data <= v[15:8];
      wr(PHAD_OFF_OD_SEL, {24'h0, v[23:16]});
      settle();
      rd(PHAD_OFF_OD_SEL, {24'h0, v[23:16]});
      p = {24'h0, ~v[7:0] | (v[23:16] & v[15:8])};
      chk(ph_drv.oe_n, p);
      chk(ph_drv.out & ~ph_drv.oe_n, v[15:8] & ~p[7:0]);
    end
    wr(PHAD_OFF_OD_SEL, 32'h0);
    rd(PHAD_OFF_ROUTE, 32'h1);
    s_en <= 1;
    for (int t = 0; t < 2; t++) begin
      s_txd <= t[0];
      m_rx <= ~t[0];
      settle();
      chk({m_oe_n, m_tx, s_rxd}, {1'b0, t[0], ~t[0]});
    end
    wr(PHAD_OFF_ROUTE, 32'h0);
    ph_dir <= 8'h01;
    for (int t = 0; t < 2; t++) begin
      s_txd <= t[0];
      ph_ext <= {7'h0, ~t[0]};
      settle();
      chk(ph_drv.oe_n[1:0], 2'b01);
      chk({m_oe_n, ph_drv.out[1], s_rxd}, {1'b1, t[0], ~t[0]});
    end
    results();
  end
endmodule
